// ### common/hppc_pkg.sv
// Package for the hub port power configuration register bank.
// Assumes one 25 MHz core clock and a synchronous active-high reset.
// Notes on behaviour
// - Disable map bit clear means port available, set means port disabled.
// - Map bits 4..1 select ports 4..1; bits 7..5 are reserved.
// - Map bit 0 is reserved, written zero and always treated as zero.
// - With remapping off, flagged ports stay disabled and cannot enumerate.
// - Any disable combination; report enabled count and renumber active ports.
// - In internal default mode the two strap pins choose disabled ports.
// - Self-powered budget holds upstream draw in 2 mA units and is reported.
// - Bus-powered budget holds upstream draw in 2 mA units and is reported.
// - Controller current holds hub silicon and board draw, 2 mA units.
// - Controller current defaults to decimal 50, meaning 100 mA.
// - Remap enable clear gives standard numbering; set gives remap mode.
package hppc_pkg;

    localparam logic [7:0] HPPC_OFS_DIS_MAP   = 8'h0B;
    localparam logic [7:0] HPPC_OFS_SP_BUDGET = 8'h0C;
    localparam logic [7:0] HPPC_OFS_BP_BUDGET = 8'h0D;
    localparam logic [7:0] HPPC_OFS_SP_CTRL   = 8'h0E;

    localparam int         HPPC_PORTS         = 4;
    localparam int         HPPC_MAP_LSB       = 1;
    localparam int         HPPC_MAP_MSB       = 4;
    localparam logic [7:0] HPPC_MAP_VALID     = 8'h1E;

    localparam logic [7:0] HPPC_RST_DIS_MAP   = 8'h00;
    localparam logic [7:0] HPPC_RST_SP_BUDGET = 8'h00;
    localparam logic [7:0] HPPC_RST_BP_BUDGET = 8'h00;
    localparam logic [7:0] HPPC_RST_SP_CTRL   = 8'h32;
    localparam logic [7:0] HPPC_MA_PER_UNIT   = 8'h02;

    typedef struct packed {
        logic       wrEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } hppc_cfg_wr_s;

    typedef struct packed {
        logic [7:0] disableMap;
        logic [7:0] spBudget;
        logic [7:0] bpBudget;
        logic [7:0] spCtrlCurrent;
    } hppc_regs_s;

endpackage

// ### logic/hppc_port_renumber.sv
// Port renumbering: active physical ports get consecutive logical numbers.
// Assumes a purely combinational use inside the register bank.
`timescale 1ns/100ps
module hppc_port_renumber
    import hppc_pkg::*;
#(
    parameter int PORTS = HPPC_PORTS
) (
    input  wire logic [PORTS-1:0]   portDisabled,
    output logic      [2:0]         enabledCount,
    output logic      [PORTS*3-1:0] logicalNum
);
    logic [2:0] runCount [PORTS:0];

    assign runCount[0] = 3'h0;

    genvar i;
    generate
        for (i = 0; i < PORTS; i++) begin : g_port
            // Active port takes the next number; disabled one reads zero
            assign runCount[i+1] = runCount[i] +
                                   {2'h0, ~portDisabled[i]};
            assign logicalNum[i*3 +: 3] = portDisabled[i] ? 3'h0
                                        : runCount[i] + 3'h1;
        end
    endgenerate

    assign enabledCount = runCount[PORTS];
endmodule

// ### logic/hppc_config_regs.sv
// Bus- and self-powered port disable and power budget configuration bytes.
// Assumes a config loader (EEPROM or SMBus) that writes one byte per cycle.
`timescale 1ns/100ps
module hppc_config_regs
    import hppc_pkg::*;
#(
    parameter int PORTS = HPPC_PORTS
) (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire hppc_cfg_wr_s       cfgWr,
    input  wire logic [7:0]         cfgRdAddr,
    input  wire logic               useDefaults,
    input  wire logic [1:0]         disableStrapPins,
    input  wire logic               remapEnable,
    output logic      [7:0]         cfgRdData,
    output logic      [PORTS-1:0]   portDisabled,
    output logic      [2:0]         enabledPortCount,
    output logic      [PORTS*3-1:0] portLogicalNum,
    output logic      [7:0]         spPowerBudget,
    output logic      [7:0]         bpPowerBudget,
    output logic      [7:0]         spControllerCurrent
);
    typedef struct packed {
        hppc_regs_s regs;
        logic [7:0] rdData;
    } hppc_state_s;

    hppc_state_s state_reg;
    hppc_state_s state_next;
    logic [7:0]  strapMap;
    logic [7:0]  effMap;
    logic [PORTS-1:0] rawDisable;

    // Strap code n disables the top n ports
    always_comb begin
        case (disableStrapPins)
            2'h0:    strapMap = 8'h00;
            2'h1:    strapMap = 8'h10;
            2'h2:    strapMap = 8'h18;
            default: strapMap = 8'h1C;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        if (cfgWr.wrEn) begin
            if (cfgWr.addr == HPPC_OFS_DIS_MAP) begin
                // Reserved bits stored as zero
                state_next.regs.disableMap =
                    cfgWr.wrData & HPPC_MAP_VALID;
            end else if (cfgWr.addr == HPPC_OFS_SP_BUDGET) begin
                state_next.regs.spBudget = cfgWr.wrData;
            end else if (cfgWr.addr == HPPC_OFS_BP_BUDGET) begin
                state_next.regs.bpBudget = cfgWr.wrData;
            end else if (cfgWr.addr == HPPC_OFS_SP_CTRL) begin
                state_next.regs.spCtrlCurrent = cfgWr.wrData;
            end
        end
        if (cfgRdAddr == HPPC_OFS_DIS_MAP) begin
            state_next.rdData = state_reg.regs.disableMap;
        end else if (cfgRdAddr == HPPC_OFS_SP_BUDGET) begin
            state_next.rdData = state_reg.regs.spBudget;
        end else if (cfgRdAddr == HPPC_OFS_BP_BUDGET) begin
            state_next.rdData = state_reg.regs.bpBudget;
        end else if (cfgRdAddr == HPPC_OFS_SP_CTRL) begin
            state_next.rdData = state_reg.regs.spCtrlCurrent;
        end else begin
            state_next.rdData = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg.regs.disableMap    <= HPPC_RST_DIS_MAP;
            state_reg.regs.spBudget      <= HPPC_RST_SP_BUDGET;
            state_reg.regs.bpBudget      <= HPPC_RST_BP_BUDGET;
            state_reg.regs.spCtrlCurrent <= HPPC_RST_SP_CTRL;
            state_reg.rdData             <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    // Defaults come from straps, else from the loaded map
    assign effMap = useDefaults ? strapMap
                  : state_reg.regs.disableMap;
    // Set bit hides the port only in standard mode
    assign rawDisable = effMap[HPPC_MAP_MSB:HPPC_MAP_LSB];
    assign portDisabled = remapEnable ? '0 : rawDisable;

    hppc_port_renumber #(
        .PORTS (PORTS)
    ) u_renumber (
        .portDisabled (portDisabled),
        .enabledCount (enabledPortCount),
        .logicalNum   (portLogicalNum)
    );

    assign cfgRdData           = state_reg.rdData;
    assign spPowerBudget       = state_reg.regs.spBudget;
    assign bpPowerBudget       = state_reg.regs.bpBudget;
    assign spControllerCurrent = state_reg.regs.spCtrlCurrent;

    // Reserved map bits and stored bytes
    map_bit0_zero_a: assert property (@(posedge clk)
        disable iff (srst)
        state_reg.regs.disableMap[0] == 1'h0 &&
        state_reg.regs.disableMap[7:5] == 3'h0)
        else $error("reserved map bits not zero");

    map_write_lands_a: assert property (@(posedge clk)
        disable iff (srst)
        cfgWr.wrEn && cfgWr.addr == HPPC_OFS_DIS_MAP |=>
        state_reg.regs.disableMap ==
            ($past(cfgWr.wrData) & HPPC_MAP_VALID))
        else $error("disable map write lost");

    sp_budget_a: assert property (@(posedge clk)
        disable iff (srst)
        cfgWr.wrEn && cfgWr.addr == HPPC_OFS_SP_BUDGET |=>
        spPowerBudget == $past(cfgWr.wrData))
        else $error("sp budget not stored");

    bp_budget_a: assert property (@(posedge clk)
        disable iff (srst)
        cfgWr.wrEn && cfgWr.addr == HPPC_OFS_BP_BUDGET |=>
        bpPowerBudget == $past(cfgWr.wrData))
        else $error("bp budget not stored");

    ctrl_current_a: assert property (@(posedge clk)
        disable iff (srst)
        cfgWr.wrEn && cfgWr.addr == HPPC_OFS_SP_CTRL |=>
        spControllerCurrent == $past(cfgWr.wrData))
        else $error("controller current not stored");

    // Reset values
    reset_default_a: assert property (@(posedge clk)
        srst |=> spControllerCurrent == HPPC_RST_SP_CTRL)
        else $error("controller current default wrong");

    map_reset_val_a: assert property (@(posedge clk)
        srst |=> state_reg.regs.disableMap == HPPC_RST_DIS_MAP)
        else $error("map reset value wrong");

    sp_reset_val_a: assert property (@(posedge clk)
        srst |=> spPowerBudget == HPPC_RST_SP_BUDGET)
        else $error("sp budget reset value wrong");

    bp_reset_val_a: assert property (@(posedge clk)
        srst |=> bpPowerBudget == HPPC_RST_BP_BUDGET)
        else $error("bp budget reset value wrong");

    rd_reset_val_a: assert property (@(posedge clk)
        srst |=> cfgRdData == 8'h00)
        else $error("read data reset value wrong");

    // Bytes change only on a write to their own offset
    hold_value_a: assert property (@(posedge clk)
        disable iff (srst)
        !cfgWr.wrEn |=> $stable(state_reg.regs))
        else $error("register changed without load");

    unmapped_wr_a: assert property (@(posedge clk)
        disable iff (srst)
        cfgWr.wrEn && (cfgWr.addr < HPPC_OFS_DIS_MAP ||
                       cfgWr.addr > HPPC_OFS_SP_CTRL) |=>
        $stable(state_reg.regs))
        else $error("unmapped write changed a register");

    map_hold_a: assert property (@(posedge clk)
        disable iff (srst)
        !(cfgWr.wrEn && cfgWr.addr == HPPC_OFS_DIS_MAP) |=>
        $stable(state_reg.regs.disableMap))
        else $error("map changed without its write");

    sp_hold_a: assert property (@(posedge clk)
        disable iff (srst)
        !(cfgWr.wrEn && cfgWr.addr == HPPC_OFS_SP_BUDGET) |=>
        $stable(spPowerBudget))
        else $error("sp budget changed without its write");

    bp_hold_a: assert property (@(posedge clk)
        disable iff (srst)
        !(cfgWr.wrEn && cfgWr.addr == HPPC_OFS_BP_BUDGET) |=>
        $stable(bpPowerBudget))
        else $error("bp budget changed without its write");

    ctrl_hold_a: assert property (@(posedge clk)
        disable iff (srst)
        !(cfgWr.wrEn && cfgWr.addr == HPPC_OFS_SP_CTRL) |=>
        $stable(spControllerCurrent))
        else $error("controller current changed without write");

    // Read data shows the byte addressed one cycle earlier
    read_back_a: assert property (@(posedge clk)
        disable iff (srst)
        cfgRdAddr == HPPC_OFS_BP_BUDGET && !cfgWr.wrEn ##1 !cfgWr.wrEn
        |-> cfgRdData == bpPowerBudget)
        else $error("read data mismatch");

    rd_map_a: assert property (@(posedge clk)
        disable iff (srst)
        cfgRdAddr == HPPC_OFS_DIS_MAP |=>
        cfgRdData == $past(state_reg.regs.disableMap))
        else $error("map read data wrong");

    rd_sp_a: assert property (@(posedge clk)
        disable iff (srst)
        cfgRdAddr == HPPC_OFS_SP_BUDGET |=>
        cfgRdData == $past(spPowerBudget))
        else $error("sp budget read data wrong");

    rd_ctrl_a: assert property (@(posedge clk)
        disable iff (srst)
        cfgRdAddr == HPPC_OFS_SP_CTRL |=>
        cfgRdData == $past(spControllerCurrent))
        else $error("controller current read data wrong");

    rd_unmapped_a: assert property (@(posedge clk)
        disable iff (srst)
        cfgRdAddr < HPPC_OFS_DIS_MAP ||
        cfgRdAddr > HPPC_OFS_SP_CTRL |=>
        cfgRdData == 8'h00)
        else $error("unmapped read not zero");

    // Port disabling, count and numbering
    disable_std_a: assert property (@(posedge clk)
        disable iff (srst)
        !remapEnable && !useDefaults |->
        portDisabled == state_reg.regs.disableMap[4:1])
        else $error("standard mode disable wrong");

    remap_off_a: assert property (@(posedge clk)
        disable iff (srst)
        remapEnable |-> portDisabled == '0)
        else $error("remap mode still disables");

    strap_mode_a: assert property (@(posedge clk)
        disable iff (srst)
        useDefaults && !remapEnable && disableStrapPins == 2'h3 |->
        portDisabled == 4'hE && enabledPortCount == 3'h1)
        else $error("strap default wrong");

    strap_count_a: assert property (@(posedge clk)
        disable iff (srst)
        useDefaults && !remapEnable |->
        enabledPortCount == 3'(PORTS - int'(disableStrapPins)))
        else $error("strap mode port count wrong");

    count_match_a: assert property (@(posedge clk)
        disable iff (srst)
        enabledPortCount == 3'(PORTS - $countones(portDisabled)))
        else $error("enabled port count wrong");

    count_max_a: assert property (@(posedge clk)
        disable iff (srst)
        enabledPortCount <= 3'(PORTS))
        else $error("more ports reported than exist");

    remap_count_a: assert property (@(posedge clk)
        disable iff (srst)
        remapEnable |-> enabledPortCount == 3'(PORTS))
        else $error("remap mode hides a port");

    first_port_a: assert property (@(posedge clk)
        disable iff (srst)
        !portDisabled[0] |-> portLogicalNum[2:0] == 3'h1)
        else $error("first active port not number one");

    generate
        for (genvar p = 0; p < PORTS; p++) begin : g_port_chk
            off_no_number_a: assert property (@(posedge clk)
                disable iff (srst)
                portDisabled[p] |-> portLogicalNum[p*3 +: 3] == 3'h0)
                else $error("disabled port still numbered");

            on_numbered_a: assert property (@(posedge clk)
                disable iff (srst)
                !portDisabled[p] |->
                portLogicalNum[p*3 +: 3] != 3'h0 &&
                portLogicalNum[p*3 +: 3] <= enabledPortCount)
                else $error("enabled port number out of range");

            std_map_bit_a: assert property (@(posedge clk)
                disable iff (srst)
                !remapEnable && !useDefaults |->
                portDisabled[p] ==
                    state_reg.regs.disableMap[p+HPPC_MAP_LSB])
                else $error("port ignores its map bit");

            strap_port_a: assert property (@(posedge clk)
                disable iff (srst)
                useDefaults && !remapEnable |->
                portDisabled[p] == (int'(disableStrapPins) + p >= PORTS))
                else $error("strap pins disable wrong port");

            remap_number_a: assert property (@(posedge clk)
                disable iff (srst)
                remapEnable |->
                portLogicalNum[p*3 +: 3] == 3'(p + 1))
                else $error("remap mode numbering wrong");
        end
    endgenerate
endmodule

// ### test/hppc_cfg_loader.sv
// Config source model: EEPROM or SMBus host writing one byte per call.
// Assumes calls are made by the bench just after a rising clk edge.
`timescale 1ns/100ps
module hppc_cfg_loader
    import hppc_pkg::*;
(
    input  wire logic   clk,
    output hppc_cfg_wr_s cfgWr
);
    initial cfgWr = '0;
    // Budget values come from the bench already covering the board
    task automatic put(input logic [7:0] a, input logic [7:0] d,
                       input logic raw);
        @(posedge clk);
        #1;
        cfgWr.addr = a;
        // Reserved map bit 0 sent as zero unless a raw write is asked
        cfgWr.wrData = (a == HPPC_OFS_DIS_MAP && !raw) ? (d & 8'hFE) : d;
        cfgWr.wrEn = 1'b1;
    endtask
    task automatic idle();
        @(posedge clk);
        #1;
        cfgWr.wrEn = 1'b0;
    endtask
endmodule

// ### test/hppc_config_regs_tb.sv
// Self-checking bench for the port disable and power budget registers.
// Assumes the config source model drives the write port.
`timescale 1ns/100ps
module hppc_config_regs_tb
    import hppc_pkg::*;
;
    logic clk = 0, srst = 1, useDefaults = 0, remapEnable = 0;
    logic [7:0] cfgRdAddr = 8'h00, cfgRdData, spB, bpB, spC;
    logic [1:0] strap = 2'h0;
    logic [3:0] portDisabled;
    logic [2:0] cnt;
    logic [11:0] num;
    hppc_cfg_wr_s cfgWr;
    int badCount = 0, totalChecks = 0;
    always #20 clk = ~clk;
    hppc_cfg_loader src (.clk(clk), .cfgWr(cfgWr));
    hppc_config_regs dut (.clk(clk), .srst(srst), .cfgWr(cfgWr),
        .cfgRdAddr(cfgRdAddr), .useDefaults(useDefaults),
        .disableStrapPins(strap), .remapEnable(remapEnable),
        .cfgRdData(cfgRdData), .portDisabled(portDisabled),
        .enabledPortCount(cnt), .portLogicalNum(num),
        .spPowerBudget(spB), .bpPowerBudget(bpB),
        .spControllerCurrent(spC));
    task automatic chk(input string n, input logic [11:0] seen, exp);
        totalChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #1 cfgRdAddr = a;
        @(posedge clk);
        #1 chk("cfgRdData", {4'h0, cfgRdData}, {4'h0, e});
    endtask
    task automatic prt(input logic [3:0] d, input logic [2:0] c,
                       input logic [11:0] n);
        chk("portDisabled", {8'h00, portDisabled}, {8'h00, d});
        chk("enabledPortCount", {9'h000, cnt}, {9'h000, c});
        chk("portLogicalNum", num, n);
    endtask
    task automatic resetVals();
        rd(8'h0B, 8'h00);
        rd(8'h0C, 8'h00);
        rd(8'h0D, 8'h00);
        rd(8'h0E, 8'h32);
        chk("spControllerCurrent", {4'h0, spC}, 12'h032);
        rd(8'h20, 8'h00);
    endtask
    task automatic mapTest();
        src.put(8'h0B, 8'hFF, 1'b1);
        src.idle();
        rd(8'h0B, 8'h1E);
        prt(4'hF, 3'h0, 12'h000);
        src.put(8'h0B, 8'h0A, 1'b0);
        src.idle();
        prt(4'h5, 3'h2, {3'h2, 3'h0, 3'h1, 3'h0});
        rd(8'h0B, 8'h0A);
    endtask
    task automatic remapTest();
        @(posedge clk);
        #1 remapEnable = 1;
        #1 prt(4'h0, 3'h4, {3'h4, 3'h3, 3'h2, 3'h1});
        @(posedge clk);
        #1 remapEnable = 0;
        #1 prt(4'h5, 3'h2, {3'h2, 3'h0, 3'h1, 3'h0});
    endtask
    task automatic strapTest();
        for (int n = 0; n < 4; n++) begin
            @(posedge clk);
            #1 useDefaults = 1;
            strap = 2'(n);
            #1 chk("strapMap", {8'h00, portDisabled},
                   {8'h00, 4'(8'hF0 >> n)});
            chk("strapCount", {9'h000, cnt}, {9'h000, 3'(4 - n)});
        end
        @(posedge clk);
        #1 useDefaults = 0;
    endtask
    task automatic budgetTest();
        src.put(8'h0C, 8'h32, 1'b0);
        src.put(8'h0D, 8'hFA, 1'b0);
        src.put(8'h0E, 8'h19, 1'b0);
        src.put(8'h0F, 8'h77, 1'b0);
        src.idle();
        chk("spPowerBudget", {4'h0, spB}, 12'h032);
        chk("bpPowerBudget", {4'h0, bpB}, 12'h0FA);
        chk("spControllerCurrent", {4'h0, spC}, 12'h019);
        rd(8'h0F, 8'h00);
        rd(8'h0D, 8'hFA);
    endtask
    // Mid-run reset must bring back every reset value
    task automatic resetTest();
        @(posedge clk);
        #1 srst = 1;
        repeat (2) @(posedge clk);
        #1 srst = 0;
        resetVals();
    endtask
    task automatic summarize();
        if (badCount == 0 && totalChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        badCount++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 srst = 0;
        resetVals();
        mapTest();
        remapTest();
        strapTest();
        budgetTest();
        resetTest();
        summarize();
    end
endmodule
